// [shared/lbm_consts.svh]
`ifndef LBM_CONSTS_SVH
`define LBM_CONSTS_SVH
// register word indices; ADDR_OF gives the byte address, four times the index
`define IDX_CEILING 8'h5a
`define IDX_LEAK 8'h5b
`define IDX_UPPER 8'h58
`define IDX_LOWER 8'h59
`define IDX_STATUS 8'h60
`define IDX_MASK 8'h61
`define IDX_LEVEL 8'h62
`define ADDR_OF(i) ({(i), 2'b00})
// reset values
`define RST_CEILING 8'h08
`define RST_LEAK 2'h1
`define RST_UPPER 8'h06
`define RST_LOWER 8'h04
`define RST_MASK 2'h0
// fields
`define LEAK_LSB 0
`define LEAK_MSB 1
`define ST_ALARM_SET 0
`define ST_ALARM_CLR 1
// timing
`define CLK_PERIOD_PS 5000
`define FILL_CYCLE_MS 128
`define FILL_CYCLE_CLKS ((`FILL_CYCLE_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// [shared/lbm_pkg.sv]
`default_nettype none
package lbm_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] leak_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_e;
endpackage
`default_nettype wire

// [src/fill_tick.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lbm_consts.svh"
module fill_tick #(
  parameter logic [31:0] CLKS = 32'(`FILL_CYCLE_CLKS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // end of fill cycle
  output logic tick
);
  logic [31:0] cnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 32'h0;
    end else if (cnt_r == CLKS - 32'h1) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
  assign tick = (cnt_r == CLKS - 32'h1);
endmodule
`default_nettype wire

// [src/leak_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lbm_consts.svh"
module leak_timer
  import lbm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fill cycle end and its verdict
  input wire logic tick,
  input wire logic bad,
  input wire lbm_pkg::leak_t rate,
  // leak period completed stable
  output logic leak
);
  logic [2:0] cnt_r;
  logic [2:0] last;
  // last count of the leak period, one less than its length
  always_comb begin
    last = 3'((4'h1 << rate) - 4'h1);
  end
  // a bad cycle restarts the stable period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
    end else if (tick) begin
      if (bad || cnt_r >= last) begin
        cnt_r <= 3'h0;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end
  assign leak = tick && !bad && (cnt_r >= last);
endmodule
`default_nettype wire

// [src/leaky_bucket_input_monitor.sv]
// How it works
// RQ1: fill cycles of 128 ms from the clock, one decision per cycle.
// RQ2: a bad or erratic cycle adds exactly one at cycle end.
// RQ3: each stable leak period of 1, 2, 4 or 8 cycles subtracts one.
// RQ4: accumulator holds at the ceiling despite further bad cycles.
// RQ5: rate field 00/01/10/11 leaks every 1, 2, 4, 8 fill cycles.
// RQ6: ceiling register is 8 bits, read/write, resets to eight.
// RQ7: rate in bits 1:0 resetting to 01; bits 7:2 read zero.
// RQ8: alarm rises when the accumulator reaches the upper threshold.
// RQ9: alarm holds until accumulator is at or below lower threshold.
// RQ10: accumulator never goes below zero.
`timescale 1ns/1ps
`default_nettype none
`include "lbm_consts.svh"
module leaky_bucket_input_monitor
  import lbm_pkg::*;
#(
  parameter logic [31:0] FILL_CLKS = 32'(`FILL_CYCLE_CLKS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // activity monitor
  input wire logic input_bad,
  // alarm and interrupt
  output logic alarm,
  output logic irq,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import lbm_pkg::*;

  // only the low twelve address bits decode; higher bits alias
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[11:0] == {2'b00, `ADDR_OF(idx)});
  endfunction

  // one list of decoded slots serves both the write and the read answer
  function automatic logic mapped(input logic [31:0] a);
    mapped = hit(a, `IDX_CEILING)
      || hit(a, `IDX_LEAK)
      || hit(a, `IDX_UPPER)
      || hit(a, `IDX_LOWER)
      || hit(a, `IDX_STATUS)
      || hit(a, `IDX_MASK)
      || hit(a, `IDX_LEVEL);
  endfunction

  byte_t ceiling_r;
  leak_t leak_rate_r;
  byte_t upper_r;
  byte_t lower_r;
  byte_t level_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic alarm_r;
  logic bad_seen_r;
  logic tick;
  logic leak;
  logic cycle_bad;

  // write channel state
  logic [31:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic wr_go;
  rd_state_e rd_state_r;
  logic rd_status;
  logic alarm_rise;
  logic alarm_fall;
  logic wr_ok;
  logic wr_ceiling;
  logic wr_leak;
  logic wr_upper;
  logic wr_lower;
  logic wr_mask;
  logic [31:0] rd_word;
  logic rd_miss;

  // the tick lands on the last clock of each fill cycle
  // RQ1: fill cycle tick
  fill_tick #(
    .CLKS(FILL_CLKS)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .tick(tick)
  );

  // the leak timer restarts on any bad cycle
  // RQ3: leak period timer
  leak_timer u_leak (
    .clk(clk),
    .rstn(rstn),
    .tick(tick),
    .bad(cycle_bad),
    .rate(leak_rate_r),
    .leak(leak)
  );

  // failure anywhere in the cycle counts, including the last clock
  assign cycle_bad = bad_seen_r || input_bad;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bad_seen_r <= 1'b0;
    end else if (tick) begin
      bad_seen_r <= 1'b0;
    end else if (input_bad) begin
      bad_seen_r <= 1'b1;
    end
  end

  // the level only moves on a tick, so software sees a slow counter
  // accumulator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_r <= 8'h00;
    end else if (tick) begin
      if (cycle_bad) begin
        // RQ2: increment by one
        // RQ4: stop at ceiling
        if (level_r < ceiling_r) begin
          level_r <= level_r + 8'h01;
        end
      end else if (leak && level_r != 8'h00) begin
        // RQ10: floor at zero
        level_r <= level_r - 8'h01;
      end
    end
  end

  // the same two conditions drive the alarm and its sticky events
  assign alarm_rise = !alarm_r && level_r >= upper_r;
  assign alarm_fall = alarm_r && level_r <= lower_r;

  // RQ8: raise at upper
  // RQ9: clear at or below lower
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alarm_r <= 1'b0;
    end else if (alarm_rise) begin
      alarm_r <= 1'b1;
    end else if (alarm_fall) begin
      alarm_r <= 1'b0;
    end
  end
  assign alarm = alarm_r;

  // sticky events; a new event beats the read that clears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= 2'h0;
    end else begin
      if (alarm_rise) begin
        status_r[`ST_ALARM_SET] <= 1'b1;
      end else if (rd_status) begin
        status_r[`ST_ALARM_SET] <= 1'b0;
      end
      if (alarm_fall) begin
        status_r[`ST_ALARM_CLR] <= 1'b1;
      end else if (rd_status) begin
        status_r[`ST_ALARM_CLR] <= 1'b0;
      end
    end
  end

  // irq stays high until a status read or the mask clears it
  assign irq = |(status_r & mask_r);

  // write path: address and data taken in either order
  // bvalid blocks both readies, so a new write waits for the answer
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 32'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      // a write to a read-only or unmapped slot changes nothing
      s_axi_bresp <= mapped(aw_addr_r) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // one strobe per register; a cleared lane 0 writes nothing
  assign wr_ok = wr_go && w_strb_r[0];
  assign wr_ceiling = wr_ok && hit(aw_addr_r, `IDX_CEILING);
  assign wr_leak = wr_ok && hit(aw_addr_r, `IDX_LEAK);
  assign wr_upper = wr_ok && hit(aw_addr_r, `IDX_UPPER);
  assign wr_lower = wr_ok && hit(aw_addr_r, `IDX_LOWER);
  assign wr_mask = wr_ok && hit(aw_addr_r, `IDX_MASK);

  // RQ6: ceiling register
  // RQ7: rate field reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ceiling_r <= `RST_CEILING;
      leak_rate_r <= `RST_LEAK;
      upper_r <= `RST_UPPER;
      lower_r <= `RST_LOWER;
      mask_r <= `RST_MASK;
    end else begin
      if (wr_ceiling) begin
        ceiling_r <= w_data_r[7:0];
      end
      // RQ5: rate select
      if (wr_leak) begin
        leak_rate_r <= w_data_r[`LEAK_MSB:`LEAK_LSB];
      end
      if (wr_upper) begin
        upper_r <= w_data_r[7:0];
      end
      if (wr_lower) begin
        lower_r <= w_data_r[7:0];
      end
      if (wr_mask) begin
        mask_r <= w_data_r[1:0];
      end
    end
  end

  // read path: one answer per address, one cycle later
  // arready drops while an answer waits, so reads never overlap
  assign s_axi_arready = (rd_state_r == RD_IDLE);
  assign rd_status = s_axi_arvalid && s_axi_arready
    && hit(s_axi_araddr, `IDX_STATUS);
  assign s_axi_rvalid = (rd_state_r == RD_RESP);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_state_r <= RD_IDLE;
    end else begin
      unique case (rd_state_r)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_r <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_r <= RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= RD_IDLE;
        end
      endcase
    end
  end

  // decode in one place so the answer register loads a single word
  always_comb begin
    rd_word = 32'h0;
    rd_miss = !mapped(s_axi_araddr);
    if (hit(s_axi_araddr, `IDX_CEILING)) begin
      rd_word = {24'h0, ceiling_r};
    end else if (hit(s_axi_araddr, `IDX_LEAK)) begin
      // RQ7: unused bits zero
      rd_word = {30'h0, leak_rate_r};
    end else if (hit(s_axi_araddr, `IDX_UPPER)) begin
      rd_word = {24'h0, upper_r};
    end else if (hit(s_axi_araddr, `IDX_LOWER)) begin
      rd_word = {24'h0, lower_r};
    end else if (hit(s_axi_araddr, `IDX_STATUS)) begin
      rd_word = {29'h0, alarm_r, status_r};
    end else if (hit(s_axi_araddr, `IDX_MASK)) begin
      rd_word = {30'h0, mask_r};
    end else if (hit(s_axi_araddr, `IDX_LEVEL)) begin
      rd_word = {24'h0, level_r};
    end
  end

  // data loads only on a handshake, so it stands while rvalid waits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rdata <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= rd_word;
    end
  end

  // a miss answers with an error and a zero word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rresp <= rd_miss ? `AXI_SLVERR : `AXI_OKAY;
    end
  end
endmodule
`default_nettype wire

// [testbench/lbm_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module lbm_chk #(
  parameter logic [31:0] FILL_CLKS = 32'd8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // alarm and bus
  input wire logic alarm,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [31:0] gap_r;
  // alarm follows level and the upper and lower thresholds; level moves once per fill cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      gap_r <= FILL_CLKS;
    else if ($changed(alarm))
      gap_r <= 32'd1;
    else if (gap_r < FILL_CLKS)
      gap_r <= gap_r + 32'd1;
  end
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_ans;
    s_wr |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_r_ans;
    s_rd |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_unmap;
    s_rd ##0 (s_axi_araddr[11:0] == 12'h000)
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  property p_rate_bits;
    s_rd ##0 (s_axi_araddr[11:0] == 12'h16c) |=> s_axi_rdata[31:2] == '0;
  endproperty
  property p_ceil_bits;
    s_rd ##0 (s_axi_araddr[11:0] == 12'h168) |=> s_axi_rdata[31:8] == '0;
  endproperty
  property p_alarm_gap;
    $changed(alarm) |-> gap_r >= FILL_CLKS;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("bvalid late");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_ans: assert property (p_r_ans) else $error("rvalid late");
  a_r_hold: assert property (p_r_hold) else $error("read not held");
  a_ar_busy: assert property (p_ar_busy) else $error("arready busy");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_rate_bits: assert property (p_rate_bits) else $error("rate bits");
  a_ceil_bits: assert property (p_ceil_bits) else $error("ceil bits");
  a_alarm_gap: assert property (p_alarm_gap) else $error("alarm gap");
endmodule
`default_nettype wire

// [testbench/leaky_bucket_input_monitor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module leaky_bucket_input_monitor_tb;
  import lbm_pkg::*;
  localparam logic [31:0] FC = 32'd8;
  localparam logic [11:0] CEIL = 12'h168, RATE = 12'h16c, LVL = 12'h188;
  localparam logic [11:0] STAT = 12'h180, MASK = 12'h184;
  logic clk = '0, rstn = '0, input_bad = '0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic alarm, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int err_count = 0, check_count = 0;
  always #2.5 clk = ~clk;
  leaky_bucket_input_monitor #(.FILL_CLKS(FC)) dut (
    .clk, .rstn, .input_bad, .alarm, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  task chk(input string n, input logic [33:0] s, input logic [33:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watcher pairs each answer with the oldest note
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("rd", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
  end
  task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    logic pa, pw;
    exp_b.push_back(r);
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      pa = pa && s_axi_awready !== 1'b1;
      pw = pw && s_axi_wready !== 1'b1;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    // random stall so the response must be held
    repeat ($urandom % 3) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    void'($urandom(76));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(CEIL, 34'h8);
    rd(RATE, 34'h1);
    rd(12'h000, {2'h2, 32'h0});
    wr(12'h000, 32'h5, 2'h2);
    d = $urandom;
    wr(CEIL, d, 2'h0);
    rd(CEIL, {26'h0, d[7:0]});
    wr(RATE, 32'hff, 2'h0);
    rd(RATE, 34'h3);
    wr(CEIL, 32'h8, 2'h0);
    // lane 0 off: the write is answered but changes nothing
    s_axi_wstrb <= 4'he;
    wr(CEIL, 32'h33, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(CEIL, 34'h8);
    wr(MASK, 32'h3, 2'h0);
    // one bad clock is a whole bad cycle
    input_bad <= 1'b1;
    @(posedge clk);
    input_bad <= 1'b0;
    repeat (2 * FC) @(posedge clk);
    rd(LVL, 34'h1);
    input_bad <= 1'b1;
    repeat (12 * FC) @(posedge clk);
    rd(LVL, 34'h8);
    chk("alarm", {33'h0, alarm}, 34'h1);
    chk("irq", {33'h0, irq}, 34'h1);
    rd(STAT, 34'h5);
    chk("irq", {33'h0, irq}, 34'h0);
    wr(MASK, 32'h1, 2'h0);
    input_bad <= 1'b0;
    wr(RATE, 32'h0, 2'h0);
    repeat (12 * FC) @(posedge clk);
    rd(LVL, 34'h0);
    chk("alarm", {33'h0, alarm}, 34'h0);
    chk("irq", {33'h0, irq}, 34'h0);
    rd(STAT, 34'h2);
    // ceiling of one makes each leak a single step
    wr(CEIL, 32'h1, 2'h0);
    for (int r = 0; r < 4; r++) begin
      wr(RATE, 32'(r), 2'h0);
      input_bad <= 1'b1;
      repeat (3 * FC) @(posedge clk);
      input_bad <= 1'b0;
      repeat (((1 << r) - 1) * FC) @(posedge clk);
      rd(LVL, 34'h1);
      repeat (2 * FC) @(posedge clk);
      rd(LVL, 34'h0);
    end
    test_done();
  end
  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule
bind leaky_bucket_input_monitor lbm_chk #(.FILL_CLKS(FILL_CLKS)) chk_i (
  .clk, .rstn, .alarm, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire
